// ---- rtl/jms_pkg.sv ----
package jms_pkg;
    // Clock and timebase.
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [36:0] PHASE_WRAP = 37'(longint'(CLK_HZ) * 1000);
    localparam logic [31:0] MHZ_PER_HZ = 32'h0000_03e8;
    // Register byte offsets.
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_FILTER = 8'h04;
    localparam logic [7:0] OFS_CURRENT = 8'h08;
    localparam logic [7:0] OFS_SPEED = 8'h0c;
    localparam logic [7:0] OFS_ACCEL = 8'h10;
    localparam logic [7:0] OFS_START = 8'h14;
    localparam logic [7:0] OFS_FAST = 8'h18;
    localparam logic [7:0] OFS_TRAVEL = 8'h1c;
    localparam logic [7:0] OFS_DATA_SPEED = 8'h20;
    localparam logic [7:0] OFS_DATA_RATE = 8'h24;
    localparam logic [7:0] OFS_DATA_DECEL = 8'h28;
    localparam logic [7:0] OFS_DATA_CURRENT = 8'h2c;
    localparam logic [7:0] OFS_SPEED_NOW = 8'h30;
    // Reset values and legal ranges.
    localparam logic [31:0] RST_FILTER = 32'h0000_0001;
    localparam logic [31:0] MAX_FILTER = 32'h0000_00c8;
    localparam logic [31:0] RST_CURRENT = 32'h0000_03e8;
    localparam logic [31:0] MAX_CURRENT = 32'h0000_03e8;
    localparam logic [31:0] RST_SPEED = 32'h0000_03e8;
    localparam logic [31:0] MAX_SPEED = 32'h003d_0900;
    localparam logic [31:0] RST_ACCEL = 32'h000f_4240;
    localparam logic [31:0] MAX_ACCEL = 32'h3b9a_ca00;
    localparam logic [31:0] RST_START = 32'h0000_01f4;
    localparam logic [31:0] RST_FAST = 32'h0000_1388;
    localparam logic [31:0] RST_TRAVEL = 32'h0000_0001;
    localparam logic [31:0] MAX_TRAVEL = 32'h007f_ffff;
    localparam logic [31:0] MIN_ONE = 32'h0000_0001;
    localparam logic [31:0] MIN_ZERO = 32'h0000_0000;
    // Synchronised input positions.
    localparam int unsigned NUM_IN = 9;
    localparam int unsigned IN_STOP = 8;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} jms_state_t;
    typedef enum logic [1:0] {MD_JOG, MD_FAST, MD_STEP, MD_DATA} jms_mode_t;
endpackage

// ---- rtl/jms_sync.sv ----
`timescale 1ns/1ps
module jms_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // jms_sync

// ---- rtl/jms_step_gen.sv ----
`timescale 1ns/1ps
module jms_step_gen
    import jms_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Enable and rate in millihertz
    input wire logic en,
    input wire logic [31:0] rate_mhz,
    // Step output
    output logic step
);
    logic [36:0] phase;
    logic [36:0] next_phase;

    // Phase accumulator in millihertz keeps low speeds exact without a divider.
    assign next_phase = phase + {5'h00, rate_mhz};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= '0;
            step <= 1'b0;
        end
        else if (!en)
        begin
            phase <= '0;
            step <= 1'b0;
        end
        else if (next_phase >= PHASE_WRAP)
        begin
            phase <= next_phase - PHASE_WRAP;
            step <= 1'b1;
        end
        else
        begin
            phase <= next_phase;
            step <= 1'b0;
        end
    end
endmodule // jms_step_gen

// ---- rtl/jms_sequencer.sv ----
`timescale 1ns/1ps
module jms_sequencer #(
    parameter int unsigned MS_CYCLES = jms_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger pins
    input wire logic fwd_continuous_trigger,
    input wire logic rev_continuous_trigger,
    input wire logic fwd_fast_trigger,
    input wire logic rev_fast_trigger,
    input wire logic fwd_step_trigger,
    input wire logic rev_step_trigger,
    input wire logic fwd_data_trigger,
    input wire logic rev_data_trigger,
    input wire logic stop_request,
    // Motor and status
    output logic step_pulse,
    output logic motor_dir,
    output logic [9:0] current_level,
    output logic ready,
    output logic moving,
    output logic in_pos
);
    import jms_pkg::*;

    logic [NUM_IN-1:0] pins_sync;
    logic [NUM_IN-1:0] pins_q;
    logic [19:0] ms_cnt;
    logic ms_tick;
    logic [31:0] filter_tc, jog_current, jog_speed, jog_accel, start_speed, fast_speed, travel;
    logic [31:0] data_speed, data_rate, data_decel, data_current;
    logic [31:0] rd_data;
    logic hit;
    jms_state_t state;
    jms_mode_t mode;
    logic aborted;
    logic [31:0] prof, filt;
    logic [22:0] remaining, accel_steps;
    logic start_ok, start_dir, hold, gen_en;
    jms_mode_t start_mode;
    logic [31:0] target, acc_rate, dec_rate, start_mhz;
    logic [32:0] up_sum;
    logic [31:0] down_val;

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [31:0] to_mhz(input logic [31:0] hz);
        return 32'(hz * MHZ_PER_HZ);
    endfunction

    jms_sync #(.WIDTH(NUM_IN)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({stop_request, rev_data_trigger, fwd_data_trigger, rev_step_trigger, fwd_step_trigger,
              rev_fast_trigger, fwd_fast_trigger, rev_continuous_trigger, fwd_continuous_trigger}),
        .dout(pins_sync)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pins_q <= '0;
        else
            pins_q <= pins_sync;
    end

    // Millisecond enable drives profile and filter updates.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else if (ms_cnt == 20'(MS_CYCLES - 1))
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b1;
        end
        else
        begin
            ms_cnt <= ms_cnt + 20'h00001;
            ms_tick <= 1'b0;
        end
    end

    // One wait state lets read data come from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= !hit;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_comb
    begin
        hit = 1'b1;
        rd_data = '0;
        unique case (paddr)
            OFS_STATUS: rd_data = {26'h0, mode, motor_dir, in_pos, moving, ready};
            OFS_FILTER: rd_data = filter_tc;
            OFS_CURRENT: rd_data = jog_current;
            OFS_SPEED: rd_data = jog_speed;
            OFS_ACCEL: rd_data = jog_accel;
            OFS_START: rd_data = start_speed;
            OFS_FAST: rd_data = fast_speed;
            OFS_TRAVEL: rd_data = travel;
            OFS_DATA_SPEED: rd_data = data_speed;
            OFS_DATA_RATE: rd_data = data_rate;
            OFS_DATA_DECEL: rd_data = data_decel;
            OFS_DATA_CURRENT: rd_data = data_current;
            OFS_SPEED_NOW: rd_data = filt;
            default: hit = 1'b0;
        endcase
    end

    // Out-of-range writes saturate to the nearest legal value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filter_tc <= RST_FILTER;
            jog_current <= RST_CURRENT;
            jog_speed <= RST_SPEED;
            jog_accel <= RST_ACCEL;
            start_speed <= RST_START;
            fast_speed <= RST_FAST;
            travel <= RST_TRAVEL;
            data_speed <= RST_SPEED;
            data_rate <= RST_ACCEL;
            data_decel <= RST_ACCEL;
            data_current <= RST_CURRENT;
        end
        else if (psel && penable && pready && pwrite)
        begin
            unique case (paddr)
                OFS_FILTER: filter_tc <= clamp(pwdata, MIN_ONE, MAX_FILTER);
                OFS_CURRENT: jog_current <= clamp(pwdata, MIN_ZERO, MAX_CURRENT);
                OFS_SPEED: jog_speed <= clamp(pwdata, MIN_ONE, MAX_SPEED);
                OFS_ACCEL: jog_accel <= clamp(pwdata, MIN_ONE, MAX_ACCEL);
                OFS_START: start_speed <= clamp(pwdata, MIN_ZERO, MAX_SPEED);
                OFS_FAST: fast_speed <= clamp(pwdata, MIN_ONE, MAX_SPEED);
                OFS_TRAVEL: travel <= clamp(pwdata, MIN_ONE, MAX_TRAVEL);
                OFS_DATA_SPEED: data_speed <= clamp(pwdata, MIN_ZERO, MAX_SPEED);
                OFS_DATA_RATE: data_rate <= clamp(pwdata, MIN_ONE, MAX_ACCEL);
                OFS_DATA_DECEL: data_decel <= clamp(pwdata, MIN_ONE, MAX_ACCEL);
                OFS_DATA_CURRENT: data_current <= clamp(pwdata, MIN_ZERO, MAX_CURRENT);
                default: ;
            endcase
        end
    end

    // Fixed priority; both directions of one kind at once start neither, and a lower-priority kind may start instead.
    always_comb
    begin
        start_ok = 1'b0;
        start_dir = 1'b0;
        start_mode = MD_JOG;
        if (state == ST_IDLE && !pins_sync[IN_STOP])
        begin
            if (pins_sync[2] ^ pins_sync[3])
            begin
                start_ok = 1'b1;
                start_mode = MD_FAST;
                start_dir = pins_sync[2];
            end
            else if (pins_sync[0] ^ pins_sync[1])
            begin
                start_ok = 1'b1;
                start_dir = pins_sync[0];
            end
            else if (pins_sync[6] ^ pins_sync[7])
            begin
                start_ok = 1'b1;
                start_mode = MD_DATA;
                start_dir = pins_sync[6];
            end
            else if ((pins_sync[4] & ~pins_q[4]) ^ (pins_sync[5] & ~pins_q[5]))
            begin
                start_ok = 1'b1;
                start_mode = MD_STEP;
                start_dir = pins_sync[4];
            end
        end
    end

    always_comb
    begin
        unique case (mode)
            MD_FAST: hold = motor_dir ? pins_sync[2] : pins_sync[3];
            MD_DATA: hold = motor_dir ? pins_sync[6] : pins_sync[7];
            MD_STEP: hold = 1'b1;
            MD_JOG: hold = motor_dir ? pins_sync[0] : pins_sync[1];
        endcase
    end

    // Parameter source depends only on the motion kind.
    always_comb
    begin
        start_mhz = to_mhz(start_speed);
        acc_rate = jog_accel;
        dec_rate = jog_accel;
        unique case (mode)
            MD_FAST: target = to_mhz(fast_speed);
            MD_DATA:
            begin
                target = to_mhz(data_speed);
                acc_rate = data_rate;
                dec_rate = data_decel;
            end
            MD_STEP, MD_JOG: target = to_mhz(jog_speed);
        endcase
        up_sum = {1'b0, prof} + {1'b0, acc_rate};
        down_val = (prof > dec_rate) ? prof - dec_rate : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            mode <= MD_JOG;
            motor_dir <= 1'b1;
            aborted <= 1'b0;
            ready <= 1'b1;
            moving <= 1'b0;
            in_pos <= 1'b1;
            current_level <= RST_CURRENT[9:0];
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (start_ok)
                    begin
                        state <= ST_RUN;
                        mode <= start_mode;
                        motor_dir <= start_dir;
                        aborted <= 1'b0;
                        ready <= 1'b0;
                        moving <= 1'b1;
                        if (start_mode == MD_STEP)
                            in_pos <= 1'b0;
                        current_level <= (start_mode == MD_DATA) ? data_current[9:0] : jog_current[9:0];
                    end
                ST_RUN:
                    if (mode == MD_STEP && remaining == '0)
                    begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                        moving <= 1'b0;
                        in_pos <= 1'b1;
                    end
                    else if (pins_sync[IN_STOP])
                    begin
                        state <= ST_DECEL;
                        aborted <= 1'b1;
                    end
                    else if (!hold || (mode == MD_STEP && remaining <= accel_steps))
                        state <= ST_DECEL;
                ST_DECEL:
                    if (mode == MD_STEP && remaining == '0)
                    begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                        moving <= 1'b0;
                        in_pos <= 1'b1;
                    end
                    else if ((mode != MD_STEP || aborted) && prof == '0 && filt == '0)
                    begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                        moving <= 1'b0;
                    end
                    else if (pins_sync[IN_STOP])
                        aborted <= 1'b1;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Trapezoid in millihertz; one step of the rate per millisecond.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prof <= '0;
        else if (state == ST_IDLE)
            prof <= start_ok ? start_mhz : 32'h0000_0000;
        else if (ms_tick && state == ST_RUN)
        begin
            if (prof < target)
                prof <= (up_sum > {1'b0, target}) ? target : up_sum[31:0];
            else if (prof > target)
                prof <= (down_val < target) ? target : down_val;
        end
        else if (ms_tick)
        begin
            // Inching that was not stopped holds the starting speed until its count runs out.
            if (down_val >= start_mhz)
                prof <= down_val;
            else
                prof <= (mode == MD_STEP && !aborted) ? start_mhz : 32'h0000_0000;
        end
    end

    // Integer division stalls near the target, so small gaps snap to it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt <= '0;
        else if (mode == MD_DATA || state == ST_IDLE)
            filt <= prof;
        else if (ms_tick)
        begin
            if (prof >= filt)
                filt <= (prof - filt < filter_tc) ? prof : filt + (prof - filt) / filter_tc;
            else
                filt <= (filt - prof < filter_tc) ? prof : filt - (filt - prof) / filter_tc;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remaining <= '0;
            accel_steps <= '0;
        end
        else if (state == ST_IDLE)
        begin
            remaining <= travel[22:0];
            accel_steps <= '0;
        end
        else if (mode == MD_STEP && step_pulse && remaining != '0)
        begin
            remaining <= remaining - 23'h000001;
            if (state == ST_RUN && prof < target)
                accel_steps <= accel_steps + 23'h000001;
        end
    end

    assign gen_en = (state != ST_IDLE) && !(mode == MD_STEP && remaining == '0);

    jms_step_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .en(gen_en),
        .rate_mhz(filt),
        .step(step_pulse)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_start_drops_ready: assert property (start_ok |=> !ready && moving && state == ST_RUN)
        else $error("start did not drop ready");
    a_step_clears_inpos: assert property (start_ok && start_mode == MD_STEP |=> !in_pos && !ready)
        else $error("inching start kept in_pos");
    a_release_decel: assert property (state == ST_RUN && mode != MD_STEP && !hold && !pins_sync[IN_STOP]
        && !(mode == MD_STEP) |=> state == ST_DECEL)
        else $error("release did not decelerate");
    a_stop_ends_run: assert property (state == ST_RUN && pins_sync[IN_STOP] && mode != MD_STEP
        |=> state == ST_DECEL && aborted)
        else $error("stop did not end motion");
    a_step_finish: assert property (state != ST_IDLE && mode == MD_STEP && remaining == '0
        |=> ready && !moving && in_pos && state == ST_IDLE)
        else $error("inching did not finish");
    a_jog_done: assert property (state == ST_DECEL && mode != MD_STEP && prof == '0 && filt == '0
        |=> ready && !moving)
        else $error("jog stop not reported");
    a_dir_stable: assert property (state != ST_IDLE ##1 state != ST_IDLE |-> $stable(motor_dir))
        else $error("direction changed mid motion");
    a_fwd_positive: assert property (start_ok && (pins_sync[0] || pins_sync[2] || pins_sync[6]) &&
        !(pins_sync[1] || pins_sync[3] || pins_sync[7]) |=> motor_dir)
        else $error("forward trigger not positive");
    a_current_source: assert property (moving |-> current_level ==
        ((mode == MD_DATA) ? data_current[9:0] : jog_current[9:0]) || $changed(mode))
        else $error("wrong current source");
    a_no_step_idle: assert property (state == ST_IDLE ##1 state == ST_IDLE |-> !step_pulse)
        else $error("step while idle");
    a_ready_excl: assert property (!(ready && moving))
        else $error("ready and moving together");

    c_jog_run: cover property (start_ok && start_mode == MD_JOG ##[1:1000] state == ST_DECEL);
    c_step_done: cover property (state == ST_RUN && mode == MD_STEP ##[1:1000] in_pos);
    c_fast_stop: cover property (state == ST_RUN && mode == MD_FAST && pins_sync[IN_STOP]);
    c_data_run: cover property (start_ok && start_mode == MD_DATA);
endmodule // jms_sequencer

// ---- bench/jms_host.sv ----
`timescale 1ns/1ps
module jms_host (
    // Clock and status
    input wire logic pclk,
    input wire logic ready,
    // Trigger pins, stop request on the top bit
    output logic [8:0] trig
);
    initial trig = 9'h000;
    task automatic put(input int idx, input logic v);
        trig[idx] <= v;
        @(posedge pclk);
    endtask
    // A step trigger raised while busy would be lost, so wait for idle first.
    task automatic raise(input int idx);
        while (ready !== 1'b1) @(posedge pclk);
        put(idx, 1'b1);
    endtask
    task automatic inch(input int idx);
        raise(idx);
        while (ready !== 1'b0) @(posedge pclk);
        put(idx, 1'b0);
    endtask
endmodule // jms_host

// ---- bench/jms_sequencer_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
 $display("Error at %0t: got %h expected %h", $time, g, e); end end
module jms_sequencer_test;
    import jms_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, step_pulse, motor_dir, ready, moving, in_pos, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] current_level;
    logic [8:0] trig;
    int n_errors = 0, num_checks = 0, cycles = 0, steps = 0;
    logic [7:0] sa[10] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h08, 8'h20, 8'h24, 8'h28};
    logic [31:0] sv[10] = '{1, 32'h003d_0900, 32'h3b9a_ca00, 32'h000f_4240, 32'h003d_0900, 3, 32'h1f4,
        32'h003d_0900, 32'h3b9a_ca00, 32'h3b9a_ca00};
    int ks[5] = '{0, 1, 2, 3, 6};
    jms_sequencer #(.MS_CYCLES(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fwd_continuous_trigger(trig[0]), .rev_continuous_trigger(trig[1]),
        .fwd_fast_trigger(trig[2]), .rev_fast_trigger(trig[3]), .fwd_step_trigger(trig[4]),
        .rev_step_trigger(trig[5]), .fwd_data_trigger(trig[6]), .rev_data_trigger(trig[7]),
        .stop_request(trig[8]), .step_pulse, .motor_dir, .current_level, .ready, .moving, .in_pos);
    jms_host u_host (.pclk, .ready, .trig);
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (step_pulse === 1'b1) steps++;
        if (cycles > 60000)
        begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            conclude();
        end
    end
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Write a value, read it back and compare with the saturated result.
    task automatic wchk(input logic [7:0] a, input logic [31:0] w, input logic [31:0] e);
        xfer(1'b1, a, w);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // Read one register and compare it with the expected word.
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_ready();
        while (ready !== 1'b1) @(posedge pclk);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({ready, moving, in_pos}, 3'b101)
        `CHK(current_level, 10'h3e8)
        rchk(8'h00, 32'h0000_000d);
        rchk(8'h04, 32'h0000_0001);
        rchk(8'h08, 32'h0000_03e8);
        rchk(8'h0c, 32'h0000_03e8);
        rchk(8'h10, 32'h000f_4240);
        rchk(8'h14, 32'h0000_01f4);
        rchk(8'h18, 32'h0000_1388);
        rchk(8'h1c, 32'h0000_0001);
        wchk(8'h04, 32'h0000_00ff, 32'h0000_00c8);
        wchk(8'h08, 32'h0000_07d0, 32'h0000_03e8);
        wchk(8'h0c, 32'h0000_0000, 32'h0000_0001);
        wchk(8'h0c, 32'h0500_0000, 32'h003d_0900);
        wchk(8'h10, 32'h0000_0000, 32'h0000_0001);
        wchk(8'h14, 32'h0000_0000, 32'h0000_0000);
        wchk(8'h18, 32'h0500_0000, 32'h003d_0900);
        wchk(8'h1c, 32'h00ff_ffff, 32'h007f_ffff);
        xfer(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        for (int i = 0; i < 10; i++) wchk(sa[i], sv[i], sv[i]);
        wchk(8'h2c, 32'h12c, 32'h12c);
        for (int i = 0; i < 2; i++)
        begin
            steps = 0;
            u_host.inch(4 + i);
            `CHK({in_pos, moving, motor_dir}, {2'b01, i == 0})
            wait_ready();
            `CHK(steps, 3)
            `CHK({in_pos, moving}, 2'b10)
        end
        // The fast forward case is ended by the stop input with the trigger still held.
        foreach (ks[j])
        begin
            steps = 0;
            u_host.raise(ks[j]);
            while (moving !== 1'b1) @(posedge pclk);
            `CHK({ready, motor_dir}, {1'b0, ks[j] % 2 == 0})
            `CHK(current_level, ks[j] == 6 ? 10'h12c : 10'h1f4)
            repeat (100) @(posedge pclk);
            `CHK({moving, steps > 3}, 2'b11)
            u_host.put(ks[j] == 2 ? 8 : ks[j], ks[j] == 2);
            steps = 0;
            // Past the synchroniser, an immediate halt would already have dropped moving.
            repeat (6) @(posedge pclk);
            `CHK(moving, 1'b1)
            wait_ready();
            `CHK(moving, 1'b0)
            `CHK(steps > 0, 1'b1)
            u_host.put(ks[j], 1'b0);
            u_host.put(8, 1'b0);
        end
        conclude();
    end
endmodule // jms_sequencer_test
